// ---- src/afec_pkg.sv ----
// Package: register map, fields, resets and timing for the front end
package afec_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] afec_idx_fmt      = 8'h0d;  // Format / cal one index
  localparam logic [7:0] afec_idx_gcal23   = 8'h33;  // Cal two/three index
  localparam logic [7:0] afec_idx_gcal4    = 8'h34;  // Cal four index
  localparam logic [7:0] afec_idx_bw       = 8'hc0;  // Bandwidth index
  localparam logic [7:0] afec_idx_ref      = 8'hc1;  // Reference index
  localparam logic [7:0] afec_idx_span_lo  = 8'hc2;  // Span ch1-4 index
  localparam logic [7:0] afec_idx_span_hi  = 8'hc3;  // Span ch5-8 index
  localparam logic [7:0] afec_idx_cm       = 8'he0;  // Common-mode index
  localparam logic [7:0] afec_idx_status   = 8'he1;  // Status index

  // Field positions
  localparam int afec_bit_fmt      = 0;   // Output format in fmt register
  localparam int afec_bit_gcal1    = 1;   // Cal one in fmt register
  localparam int afec_bit_gcal2    = 0;   // Cal two
  localparam int afec_bit_gcal3    = 1;   // Cal three
  localparam int afec_bit_gcal4    = 0;   // Cal four
  localparam int afec_bit_vref_pd  = 0;   // Reference power-down
  localparam int afec_bit_wide_cm  = 0;   // Wide common-mode enable
  localparam int afec_bit_cm_ctrl  = 1;   // Common-mode control enable
  localparam int afec_bit_cma_en   = 2;   // Converter A cm enable
  localparam int afec_bit_cma_sp   = 3;   // Converter A cm span [4:3]
  localparam int afec_bit_cmb_en   = 5;   // Converter B cm enable
  localparam int afec_bit_cmb_sp   = 6;   // Converter B cm span [7:6]
  localparam int afec_span_w       = 3;   // Span code width
  localparam int afec_span_stride  = 4;   // Span field spacing

  // Span codes
  localparam logic [2:0] afec_span_5v0  = 3'h0;
  localparam logic [2:0] afec_span_3v5  = 3'h1;
  localparam logic [2:0] afec_span_2v5  = 3'h2;
  localparam logic [2:0] afec_span_7v0  = 3'h3;
  localparam logic [2:0] afec_span_10v  = 3'h4;
  localparam logic [2:0] afec_span_12v  = 3'h5;

  // Common-mode span codes
  localparam logic [1:0] afec_cm_half   = 2'h0;
  localparam logic [1:0] afec_cm_12v    = 2'h1;
  localparam logic [1:0] afec_cm_6v     = 2'h2;

  // Reset values
  localparam logic [7:0] afec_bw_rst    = 8'h00;
  localparam logic [2:0] afec_span_rst  = afec_span_5v0;
  localparam logic [7:0] afec_cm_rst    = 8'h02;  // Control enable set

  // Conversion code
  localparam int afec_code_w = 18;

  // Sampling clock start-up delay
  localparam int          afec_clk_mhz        = 50;
  localparam int          afec_startup_us     = 25000;  // 25 ms
  localparam int unsigned afec_startup_cycles = afec_startup_us * afec_clk_mhz;
  localparam int unsigned afec_stop_cycles    = 64;     // Missing-edge limit

  // AXI responses
  localparam logic [1:0] afec_resp_okay   = 2'h0;
  localparam logic [1:0] afec_resp_slverr = 2'h2;

  // Clock monitor states
  typedef enum logic [1:0]
  {
    afec_mon_stopped = 2'b00,
    afec_mon_warming = 2'b01,
    afec_mon_valid   = 2'b10
  } afec_mon_t;

endpackage

// ---- src/afec_code_fmt.sv ----
// Output code formatter: straight binary or two's complement
`timescale 1ns/1ps
`default_nettype none
module afec_code_fmt #(
  parameter int W = 18
) (
  input  wire logic         aclk,       // System clock
  input  wire logic         aresetn,    // Synchronous reset, active low
  input  wire logic         twos_comp,  // Select two's complement
  input  wire logic         in_valid,   // Raw code strobe
  input  wire logic [W-1:0] in_code,    // Straight-binary raw code
  output      logic         out_valid,  // Formatted code strobe
  output      logic [W-1:0] out_code    // Formatted code
);

  // Registered format; midscale maps to zero when inverting the MSB
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid <= 1'b0;
      out_code  <= '0;
    end
    else
    begin
      out_valid <= in_valid;
      out_code  <= twos_comp ? {~in_code[W-1], in_code[W-2:0]} // RQ15
                             : in_code;                        // RQ10
    end
  end

endmodule
`default_nettype wire

// ---- src/afec_top.sv ----
// Front-end configuration registers, clock monitor and output formatting
//
// Summary of operation
// (RQ1) Eight independent channel span fields, two registers
// (RQ2) Span codes 5,4,3,0,1,2 select 12..2.5 V
// (RQ3) Eight-bit bandwidth select, one bit per channel
// (RQ4) Converter A channels 1-4, B channels 5-8
// (RQ5) Reset: wide common-mode enable cleared
// (RQ6) Common-mode enable and span select rejection
// (RQ7) Host picks single-ended common-mode settings
// (RQ8) Calibration on only with all four enables
// (RQ9) Uncalibrated spans grow by factor 1.024
// (RQ10) Straight binary or two's complement, all channels
// (RQ11) Code step is span over two^18
// (RQ12) Host keeps sampling clock free-running
// (RQ13) Outputs invalid while sampling clock stopped
// (RQ14) Reference on after reset; one powers down
// (RQ15) Two's complement inverts the code MSB
// (RQ16) Fields reset to defaults, drive controls
`timescale 1ns/1ps
`default_nettype none
module afec_top #(
  parameter int unsigned STARTUP_CYCLES = afec_pkg::afec_startup_cycles,
  parameter int unsigned STOP_CYCLES    = afec_pkg::afec_stop_cycles,
  parameter int          CODE_W         = afec_pkg::afec_code_w,
  parameter int          NCH            = 8
) (
  input  wire logic              aclk,            // System clock 50 MHz
  input  wire logic              aresetn,         // Sync reset, active low
  // AXI4-Lite slave
  input  wire logic [11:0]       s_axi_awaddr,    // Write address
  input  wire logic              s_axi_awvalid,   // Write address valid
  output      logic              s_axi_awready,   // Write address ready
  input  wire logic [31:0]       s_axi_wdata,     // Write data
  input  wire logic [3:0]        s_axi_wstrb,     // Write strobes
  input  wire logic              s_axi_wvalid,    // Write data valid
  output      logic              s_axi_wready,    // Write data ready
  output      logic [1:0]        s_axi_bresp,     // Write response
  output      logic              s_axi_bvalid,    // Write response valid
  input  wire logic              s_axi_bready,    // Write response ready
  input  wire logic [11:0]       s_axi_araddr,    // Read address
  input  wire logic              s_axi_arvalid,   // Read address valid
  output      logic              s_axi_arready,   // Read address ready
  output      logic [31:0]       s_axi_rdata,     // Read data
  output      logic [1:0]        s_axi_rresp,     // Read response
  output      logic              s_axi_rvalid,    // Read data valid
  input  wire logic              s_axi_rready,    // Read data ready
  // Front-end controls
  output      logic [3*NCH-1:0]  channel_span_code,        // Per-channel span
  output      logic [NCH-1:0]    channel_bandwidth_select, // 1 = wide band
  output      logic              wide_common_mode_enable,  // Wide CM
  output      logic              common_mode_control_enable, // CM control
  output      logic              conv_a_common_mode_enable,  // Conv A CM on
  output      logic [1:0]        conv_a_common_mode_span,    // Conv A CM span
  output      logic              conv_b_common_mode_enable,  // Conv B CM on
  output      logic [1:0]        conv_b_common_mode_span,    // Conv B CM span
  output      logic              gain_cal_active,  // All four enables set
  output      logic              internal_vref_powerdown,    // Ref off
  // Sampling clock and conversion data
  input  wire logic              sample_clock_pos, // Sampling clock pin
  input  wire logic              conv_a_valid,     // Converter A raw strobe
  input  wire logic [CODE_W-1:0] conv_a_code,      // Converter A raw code
  input  wire logic              conv_b_valid,     // Converter B raw strobe
  input  wire logic [CODE_W-1:0] conv_b_code,      // Converter B raw code
  input  wire logic [1:0]        conv_a_channel,   // Converter A mux slot
  input  wire logic [1:0]        conv_b_channel,   // Converter B mux slot
  output      logic              data_out_valid,   // Output stream valid
  output      logic              out_a_valid,      // Formatted A strobe
  output      logic [CODE_W-1:0] out_a_code,       // Formatted A code
  output      logic [2:0]        out_a_channel,    // Channel 0..3 (1-4)
  output      logic              out_b_valid,      // Formatted B strobe
  output      logic [CODE_W-1:0] out_b_code,       // Formatted B code
  output      logic [2:0]        out_b_channel     // Channel 4..7 (5-8)
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [2:0]  span_q [NCH];
  logic [7:0]  bw_q;
  logic [7:0]  cm_q;
  logic        fmt_q;
  logic [3:0]  gcal_q;
  logic        vref_pd_q;
  afec_pkg::afec_mon_t mon_state;

  // Byte address of a printed offset (offsets not all aligned)
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel

  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_hit;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write address decode
  always_comb
  begin
    wr_hit = 1'b1;
    if (aw_addr == byte_addr(afec_pkg::afec_idx_fmt))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_gcal23))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_gcal4))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_bw))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_ref))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_span_lo))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_span_hi))
      wr_hit = 1'b1;
    else if (aw_addr == byte_addr(afec_pkg::afec_idx_cm))
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= afec_pkg::afec_resp_okay;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? afec_pkg::afec_resp_okay
                             : afec_pkg::afec_resp_slverr;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, reset to defaults

  logic wr_b0;
  assign wr_b0 = do_write && w_strb[0];

  // Scalar settings
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bw_q      <= afec_pkg::afec_bw_rst; // RQ16
      cm_q      <= afec_pkg::afec_cm_rst; // RQ5
      fmt_q     <= 1'b0;
      gcal_q    <= 4'h0;
      vref_pd_q <= 1'b0; // RQ14
    end
    else if (wr_b0)
    begin
      if (aw_addr == byte_addr(afec_pkg::afec_idx_bw))
        bw_q <= w_data[7:0]; // RQ3
      else if (aw_addr == byte_addr(afec_pkg::afec_idx_cm))
        cm_q <= w_data[7:0]; // RQ6
      else if (aw_addr == byte_addr(afec_pkg::afec_idx_ref))
        vref_pd_q <= w_data[afec_pkg::afec_bit_vref_pd]; // RQ14
      else if (aw_addr == byte_addr(afec_pkg::afec_idx_fmt))
      begin
        fmt_q     <= w_data[afec_pkg::afec_bit_fmt]; // RQ10
        gcal_q[0] <= w_data[afec_pkg::afec_bit_gcal1]; // RQ8
      end
      else if (aw_addr == byte_addr(afec_pkg::afec_idx_gcal23))
      begin
        gcal_q[1] <= w_data[afec_pkg::afec_bit_gcal2]; // RQ8
        gcal_q[2] <= w_data[afec_pkg::afec_bit_gcal3];
      end
      else if (aw_addr == byte_addr(afec_pkg::afec_idx_gcal4))
        gcal_q[3] <= w_data[afec_pkg::afec_bit_gcal4]; // RQ8
    end
  end

  // Per-channel span fields, four per register, each field 4 bits apart
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_span
      localparam logic [7:0] IDX = (g < 4) ? afec_pkg::afec_idx_span_lo
                                           : afec_pkg::afec_idx_span_hi;
      localparam int LSB = (g % 4) * afec_pkg::afec_span_stride;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          span_q[g] <= afec_pkg::afec_span_rst; // RQ16
        else if (do_write && w_strb[LSB/8] && aw_addr == byte_addr(IDX))
          span_q[g] <= w_data[LSB +: afec_pkg::afec_span_w]; // RQ1
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Drive the front-end controls from stored fields

  integer k;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_span_code          <= '0;
      channel_bandwidth_select   <= '0;
      wide_common_mode_enable    <= 1'b0;
      common_mode_control_enable <= 1'b0;
      conv_a_common_mode_enable  <= 1'b0;
      conv_a_common_mode_span    <= '0;
      conv_b_common_mode_enable  <= 1'b0;
      conv_b_common_mode_span    <= '0;
      gain_cal_active            <= 1'b0;
      internal_vref_powerdown    <= 1'b0;
    end
    else
    begin
      for (k = 0; k < NCH; k++)
        channel_span_code[3*k +: 3] <= span_q[k]; // RQ2
      channel_bandwidth_select   <= bw_q[NCH-1:0]; // RQ3
      wide_common_mode_enable    <= cm_q[afec_pkg::afec_bit_wide_cm];
      common_mode_control_enable <= cm_q[afec_pkg::afec_bit_cm_ctrl];
      conv_a_common_mode_enable  <= cm_q[afec_pkg::afec_bit_cma_en];
      conv_a_common_mode_span    <= cm_q[afec_pkg::afec_bit_cma_sp +: 2];
      conv_b_common_mode_enable  <= cm_q[afec_pkg::afec_bit_cmb_en];
      conv_b_common_mode_span    <= cm_q[afec_pkg::afec_bit_cmb_sp +: 2];
      gain_cal_active            <= &gcal_q;  // RQ8 RQ9 RQ11
      internal_vref_powerdown    <= vref_pd_q; // RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling clock monitor

  logic        smp_s1;
  logic        smp_s2;
  logic        smp_s3;
  logic [31:0] mon_cnt;
  logic        smp_edge;
  logic [15:0] gap_cnt;

  // Two-flop synchroniser, third flop for edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      smp_s1 <= 1'b0;
      smp_s2 <= 1'b0;
      smp_s3 <= 1'b0;
    end
    else
    begin
      smp_s1 <= sample_clock_pos;
      smp_s2 <= smp_s1;
      smp_s3 <= smp_s2;
    end
  end

  assign smp_edge = smp_s2 && !smp_s3;

  // Stopped -> warming on edges, valid after start-up delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mon_state <= afec_pkg::afec_mon_stopped;
      mon_cnt   <= '0;
    end
    else
    begin
      case (mon_state)
        afec_pkg::afec_mon_stopped:
        begin
          mon_cnt <= '0;
          if (smp_edge)
            mon_state <= afec_pkg::afec_mon_warming;
        end
        afec_pkg::afec_mon_warming:
        begin
          mon_cnt <= mon_cnt + 32'h1;
          if (gap_cnt >= STOP_CYCLES[15:0])
            mon_state <= afec_pkg::afec_mon_stopped;          // RQ13
          else if (mon_cnt >= STARTUP_CYCLES - 1)
            mon_state <= afec_pkg::afec_mon_valid;            // RQ13
        end
        afec_pkg::afec_mon_valid:
        begin
          if (gap_cnt >= STOP_CYCLES[15:0])
            mon_state <= afec_pkg::afec_mon_stopped;          // RQ13
        end
        default:
          mon_state <= afec_pkg::afec_mon_stopped;
      endcase
    end
  end

  // Cycles since last sampling clock edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn || smp_edge)
      gap_cnt <= '0;
    else if (gap_cnt != 16'hffff)
      gap_cnt <= gap_cnt + 16'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output code formatting, gated by clock validity

  logic valid_now;

  assign valid_now = (mon_state == afec_pkg::afec_mon_valid);

  afec_code_fmt #(.W(CODE_W)) u_fmt_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .twos_comp (fmt_q),
    .in_valid  (conv_a_valid && valid_now),
    .in_code   (conv_a_code),
    .out_valid (out_a_valid),
    .out_code  (out_a_code)
  );

  afec_code_fmt #(.W(CODE_W)) u_fmt_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .twos_comp (fmt_q),
    .in_valid  (conv_b_valid && valid_now),
    .in_code   (conv_b_code),
    .out_valid (out_b_valid),
    .out_code  (out_b_code)
  );

  // Channel tags: A covers channels 1-4, B covers 5-8
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_a_channel  <= '0;
      out_b_channel  <= '0;
      data_out_valid <= 1'b0;
    end
    else
    begin
      out_a_channel  <= {1'b0, conv_a_channel}; // RQ4
      out_b_channel  <= {1'b1, conv_b_channel}; // RQ4
      data_out_valid <= valid_now; // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel

  logic [31:0] rd_word;
  logic        rd_hit;

  // Read address decode
  always_comb
  begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_fmt))
      rd_word = {30'h0, gcal_q[0], fmt_q};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_gcal23))
      rd_word = {30'h0, gcal_q[2], gcal_q[1]};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_gcal4))
      rd_word = {31'h0, gcal_q[3]};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_bw))
      rd_word = {24'h0, bw_q};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_ref))
      rd_word = {31'h0, vref_pd_q};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_span_lo))
      rd_word = {16'h0, 1'b0, span_q[3], 1'b0, span_q[2],
                 1'b0, span_q[1], 1'b0, span_q[0]};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_span_hi))
      rd_word = {16'h0, 1'b0, span_q[7], 1'b0, span_q[6],
                 1'b0, span_q[5], 1'b0, span_q[4]};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_cm))
      rd_word = {24'h0, cm_q};
    else if (s_axi_araddr == byte_addr(afec_pkg::afec_idx_status))
      rd_word = {28'h0, &gcal_q, mon_state == afec_pkg::afec_mon_warming,
                 valid_now, smp_s2};
    else
      rd_hit = 1'b0;
  end

  // Read response register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= afec_pkg::afec_resp_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? afec_pkg::afec_resp_okay
                               : afec_pkg::afec_resp_slverr;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/afec_chk.sv ----
// Checker: port assertions for the front end
`timescale 1ns/1ps
`default_nettype none
module afec_chk #(
  parameter int unsigned STOP_CYCLES = 16
) (
  input wire logic        aclk,              // Clock
  input wire logic        aresetn,           // Reset
  input wire logic        s_axi_arvalid,     // AR valid
  input wire logic        s_axi_arready,     // AR ready
  input wire logic        s_axi_rvalid,      // R valid
  input wire logic        s_axi_rready,      // R ready
  input wire logic        s_axi_bvalid,      // B valid
  input wire logic [23:0] channel_span_code, // Spans
  input wire logic        sample_clock_pos,  // Sample clock
  input wire logic        conv_a_valid,      // A strobe
  input wire logic [17:0] conv_a_code,       // A raw
  input wire logic [1:0]  conv_a_channel,    // A slot
  input wire logic [17:0] conv_b_code,       // B raw
  input wire logic [1:0]  conv_b_channel,    // B slot
  input wire logic        data_out_valid,    // Stream valid
  input wire logic        out_a_valid,       // A out strobe
  input wire logic [17:0] out_a_code,        // A out
  input wire logic [2:0]  out_a_channel,     // A channel
  input wire logic        out_b_valid,       // B out strobe
  input wire logic [17:0] out_b_code,        // B out
  input wire logic [2:0]  out_b_channel      // B channel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned stall;
  logic        sc_q;
  // Cycles since the sampling clock last moved
  always_ff @(posedge aclk)
  begin
    sc_q <= sample_clock_pos;
    if (!aresetn || sample_clock_pos != sc_q)
      stall <= 0;
    else if (stall < 1000)
      stall <= stall + 1;
  end
  chk_fmt_low: assert property (out_a_valid |->
    out_a_code[16:0] == $past(conv_a_code[16:0])) else $error("A low bits");
  chk_a_cause: assert property (out_a_valid |->
    $past(conv_a_valid) && data_out_valid) else $error("A strobe");
  chk_a_chan: assert property (out_a_valid |->
    out_a_channel == {1'b0, $past(conv_a_channel)}) else $error("A chan");
  chk_b_chan: assert property (out_b_valid |->
    out_b_channel == {1'b1, $past(conv_b_channel)}) else $error("B chan");
  chk_same_fmt: assert property (out_a_valid && out_b_valid |->
    (out_a_code[17] ^ $past(conv_a_code[17])) ==
    (out_b_code[17] ^ $past(conv_b_code[17]))) else $error("Format");
  chk_clk_stop: assert property (stall >= STOP_CYCLES + 6 |->
    !data_out_valid) else $error("Valid while stopped");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("Read late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("Read dropped");
  chk_span_hold: assert property ($changed(channel_span_code)
    |-> $past(s_axi_bvalid)) else $error("Span moved");
  cover property (out_a_valid && out_b_valid);
  cover property (stall >= STOP_CYCLES + 6);
  cover property ($rose(data_out_valid));
endmodule
bind afec_top afec_chk #(.STOP_CYCLES(STOP_CYCLES)) u_afec_chk (.*);
`default_nettype wire

// ---- tb/afec_sclk_src.sv ----
// Partner: sampling clock source that can be halted
`timescale 1ns/1ps
`default_nettype none
module afec_sclk_src #(
  parameter int HALF_NS = 103
) (
  input  wire logic run,  // Clock enable
  output var  logic sclk  // Sampling clock
);
  // Toggle while running, park low when halted
  initial
  begin
    sclk = 1'b0;
    forever
    begin
      #(HALF_NS);
      sclk = run ? ~sclk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_afec_top.sv ----
// Testbench: register and data scenarios for the front end
`timescale 1ns/1ps
`default_nettype none
module tb_afec_top;
  logic        aclk, aresetn, run, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        wide_common_mode_enable, common_mode_control_enable;
  logic        conv_a_common_mode_enable, conv_b_common_mode_enable;
  logic        gain_cal_active, internal_vref_powerdown, sample_clock_pos;
  logic        conv_a_valid, conv_b_valid, data_out_valid;
  logic        out_a_valid, out_b_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, conv_a_channel, conv_b_channel;
  logic [1:0]  conv_a_common_mode_span, conv_b_common_mode_span, r;
  logic [2:0]  out_a_channel, out_b_channel;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  channel_bandwidth_select;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [17:0] conv_a_code, conv_b_code, out_a_code, out_b_code;
  logic [23:0] channel_span_code;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int          bad_count, n_compared, k;
  afec_top #(.STARTUP_CYCLES(20), .STOP_CYCLES(16)) u_afec_top (.*);
  afec_sclk_src u_afec_sclk_src (.run(run), .sclk(sample_clock_pos));
  initial
  begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic to;
    bad_count++;
    $display("BAD %0t timeout", $time);
    test_done;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic st;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
    if (i == 50) to;
  endtask
  task automatic rd(input logic [11:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    if (i == 50) to;
  endtask
  // One sample on each converter, checked a cycle later
  task automatic cv(input logic tc, input logic v);
    @(posedge aclk);
    {conv_a_valid, conv_b_valid} <= 2'h3;
    conv_a_code <= 18'h00005;
    conv_b_code <= 18'h3fffe;
    @(posedge aclk);
    {conv_a_valid, conv_b_valid} <= 2'h0;
    #1 chk({out_a_valid, out_b_valid}, {v, v});
    if (v) chk({out_a_channel, out_a_code}, {3'h3, tc, 17'h5});
    if (v) chk({out_b_channel, out_b_code}, {3'h5, ~tc, 17'h1fffe});
  endtask
  initial
  begin
    {aresetn, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, conv_a_valid, conv_b_valid} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_a_code} = 0;
    {conv_b_code, conv_a_channel, conv_b_channel} = {18'h0, 2'h3, 2'h1};
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    st;
    chk({wide_common_mode_enable, common_mode_control_enable}, 2'h1);
    chk({internal_vref_powerdown, channel_span_code}, 0);
    rd(12'h380);
    chk(d, 32'h2);
    $display("defaults done");
    wr(12'h308, 32'h345);
    wr(12'h30c, 32'h4521);
    st;
    chk(channel_span_code, 24'h9510e5);
    rd(12'h308);
    chk(d, 32'h345);
    wr(12'h300, 32'ha5);
    wr(12'h380, 32'h57);
    st;
    chk(channel_bandwidth_select, 8'ha5);
    chk({conv_b_common_mode_span, conv_b_common_mode_enable,
      conv_a_common_mode_span, conv_a_common_mode_enable,
      common_mode_control_enable, wide_common_mode_enable}, 8'h57);
    $display("config done");
    wr(12'h034, 32'h2);
    wr(12'h0cc, 32'h3);
    st;
    chk(gain_cal_active, 0);
    wr(12'h0d0, 32'h1);
    wr(12'h304, 32'h1);
    st;
    chk({gain_cal_active, internal_vref_powerdown}, 2'h3);
    wr(12'h3fc, 32'h1);
    chk(r, 2'h2);
    rd(12'h3fc);
    chk(r, 2'h2);
    $display("cal done");
    run <= 1;
    for (k = 0; k < 400 && data_out_valid !== 1'b1; k++)
      @(posedge aclk);
    if (k == 400) to;
    cv(0, 1);
    wr(12'h034, 32'h3);
    st;
    cv(1, 1);
    run <= 0;
    repeat (60) @(posedge aclk);
    cv(1, 0);
    $display("data done");
    test_done;
  end
endmodule
`default_nettype wire
